/* File: verilog/akfe_pkg.sv */
// Package of constants for the second-stage key field extractor.
package akfe_pkg;
    // ==========================================================
    // Widths of key fields and the action word.
    localparam int IP_PAYLOAD_BYTES = 12;
    localparam int TRANSPORT_PAYLOAD_BYTES = 8;
    localparam int LONG_CUSTOM_BYTES = 57;
    localparam int SHORT_CUSTOM_BYTES = 24;
    localparam int ACTION_WIDTH = 196;
    localparam int INNER_FLAG_POS = 0;
    localparam int IPV4_HEADER_BYTES = 20;
    localparam int ETH_BASE_BYTES = 14;
    localparam int VLAN_TAG_BYTES = 4;
    localparam int MAX_VLAN_TAGS = 3;
    // ==========================================================
    // Protocol values.
    localparam logic [7:0] PROTO_TCP = 8'h06;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    localparam logic [15:0] ETHERTYPE_KEY_FIELD_OAM = 16'h8902;
    localparam logic [31:0] SEQ_ZERO = 32'h00000000;
    // TCP flag bit positions within the flags byte.
    localparam int FLAG_FIN = 0;
    localparam int FLAG_SYN = 1;
    localparam int FLAG_RST = 2;
    localparam int FLAG_PSH = 3;
    localparam int FLAG_ACK = 4;
    localparam int FLAG_URG = 5;
    // Frame type codes from the earlier classifier stage.
    typedef enum logic [1:0] {
        AKFE_FT_ETH,
        AKFE_FT_IPV4,
        AKFE_FT_IPV6
    } akfe_frame_t;
endpackage : akfe_pkg

/* File: verilog/akfe_window.sv */
// Byte window selector: registered extract of a byte range from a frame buffer.
module akfe_window #(
    parameter int FRAME_BYTES = 128,
    parameter int OUT_BYTES = 8,
    parameter int PTR_W = 7
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic load,
    input wire logic [FRAME_BYTES*8-1:0] frame,
    input wire logic [PTR_W-1:0] start,
    output logic [OUT_BYTES*8-1:0] window
);
    // ==========================================================
    // Byte i of the window is frame byte start+i, zero past the end.
    logic [OUT_BYTES*8-1:0] next_window;
    genvar i;
    generate
        for (i = 0; i < OUT_BYTES; i++) begin : g_byte
            logic [PTR_W:0] idx;
            assign idx = {1'b0, start} + (PTR_W+1)'(i);
            assign next_window[i*8 +: 8] =
                (int'(idx) < FRAME_BYTES) ? frame[int'(idx)*8 +: 8] : 8'h00;
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            window <= '0;
        end else if (clk_en && load) begin
            window <= next_window;
        end
    end
endmodule : akfe_window

/* File: verilog/akfe_key_extract.sv */
// Upper key part and action flag of the second-stage access-control lookup.

// Summary of operation
// - Sequence-zero flag set when the TCP sequence number equals zero.
// - IP payload window is 12 bytes after IP header; IPv4 at 20 bytes.
// - Transport payload window holds 8 bytes after the TCP or UDP header.
// - Seven-tuple, non TCP_OR_UDP_FLAG: transport window gets IP payload bytes 0 to 7.
// - Loss-counters-zero flag set when the three CCM counters are zero.
// - EtherType 0x8902 sets OAM flag; EtherType field then carries level flags.
// - Long custom window holds 57 bytes from the classifier frame pointer.
// - Plain Ethernet frames take custom payload after the Ethernet layer.
// - Short custom window holds 24 bytes at classifier-chosen location.
// - One 196-bit action format serves every key type.
// - Action bit 0 is the inner-stage flag for the inner switch point.
// - TCP-or-UDP flag set when an IPv4 or IPv6 frame's protocol or next header is 6 or 17.
module akfe_key_extract #(
    parameter int FRAME_BYTES = 128,
    parameter int PTR_W = 7
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic frame_valid,
    input wire logic [FRAME_BYTES*8-1:0] frame,
    input wire akfe_pkg::akfe_frame_t frame_type,
    input wire logic [PTR_W-1:0] ip_header_start,
    input wire logic [PTR_W-1:0] ip_header_len,
    input wire logic [PTR_W-1:0] transport_payload_start,
    input wire logic [7:0] ip_protocol,
    input wire logic [31:0] tcp_sequence,
    input wire logic [7:0] tcp_flags,
    input wire logic [15:0] ethertype,
    input wire logic [15:0] oam_level_flags,
    input wire logic is_ccm,
    input wire logic [31:0] tx_fcf,
    input wire logic [31:0] rx_fcb,
    input wire logic [31:0] tx_fcb,
    input wire logic seven_tuple_key,
    input wire logic [1:0] vlan_tag_count,
    input wire logic [PTR_W-1:0] frame_pointer,
    input wire logic [PTR_W-1:0] short_custom_start,
    input wire logic action_valid,
    input wire logic inner_switch_point,
    input wire logic [akfe_pkg::ACTION_WIDTH-2:0] action_rest,
    output logic key_valid,
    output logic tcp_seq_zero_flag,
    output logic tcp_finish_bit,
    output logic tcp_synchronize_bit,
    output logic tcp_reset_bit,
    output logic tcp_push_bit,
    output logic tcp_acknowledge_bit,
    output logic tcp_urgent_bit,
    output logic tcp_or_udp_flag,
    output logic [akfe_pkg::IP_PAYLOAD_BYTES*8-1:0] ip_payload_window,
    output logic [akfe_pkg::TRANSPORT_PAYLOAD_BYTES*8-1:0] transport_payload_window,
    output logic loss_counters_zero_flag,
    output logic oam_ethertype_flag,
    output logic [15:0] ethertype_key_field,
    output logic [akfe_pkg::LONG_CUSTOM_BYTES*8-1:0] long_custom_window,
    output logic [akfe_pkg::SHORT_CUSTOM_BYTES*8-1:0] short_custom_window,
    output logic action_out_valid,
    output logic [akfe_pkg::ACTION_WIDTH-1:0] action_word
);
    // ==========================================================
    // Start offsets of the payload windows.
    logic [PTR_W-1:0] ip_payload_start;
    logic [PTR_W-1:0] eth_layer_end;
    logic [PTR_W-1:0] long_start;
    logic [PTR_W-1:0] short_start;
    logic [PTR_W-1:0] transport_start;
    logic next_tcp_or_udp;
    logic load;

    assign load = frame_valid;
    // IPv4 options are never parsed, so the payload is a fixed 20 bytes on.
    assign ip_payload_start = (frame_type == akfe_pkg::AKFE_FT_IPV4) ?
        ip_header_start + PTR_W'(akfe_pkg::IPV4_HEADER_BYTES) :
        ip_header_start + ip_header_len;
    // End of DMAC, SMAC, up to three tags and EtherType.
    assign eth_layer_end = PTR_W'(akfe_pkg::ETH_BASE_BYTES) +
        PTR_W'(vlan_tag_count) * PTR_W'(akfe_pkg::VLAN_TAG_BYTES);
    assign long_start = (frame_type == akfe_pkg::AKFE_FT_ETH) ?
        eth_layer_end : frame_pointer;
    assign short_start = (frame_type == akfe_pkg::AKFE_FT_ETH) ?
        eth_layer_end : short_custom_start;
    assign next_tcp_or_udp = (frame_type != akfe_pkg::AKFE_FT_ETH) &&
        (ip_protocol == akfe_pkg::PROTO_TCP ||
         ip_protocol == akfe_pkg::PROTO_UDP);
    // Non TCP_OR_UDP_FLAG seven-tuple frames reuse IP payload bytes 0 to 7.
    assign transport_start = (seven_tuple_key && !next_tcp_or_udp) ?
        ip_payload_start : transport_payload_start;

    // ==========================================================
    // Payload windows.
    akfe_window #(
        .FRAME_BYTES(FRAME_BYTES),
        .OUT_BYTES(akfe_pkg::IP_PAYLOAD_BYTES),
        .PTR_W(PTR_W)
    ) u_ip_win (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .load(load),
        .frame(frame),
        .start(ip_payload_start),
        .window(ip_payload_window)
    );

    akfe_window #(
        .FRAME_BYTES(FRAME_BYTES),
        .OUT_BYTES(akfe_pkg::TRANSPORT_PAYLOAD_BYTES),
        .PTR_W(PTR_W)
    ) u_l4_win (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .load(load),
        .frame(frame),
        .start(transport_start),
        .window(transport_payload_window)
    );

    akfe_window #(
        .FRAME_BYTES(FRAME_BYTES),
        .OUT_BYTES(akfe_pkg::LONG_CUSTOM_BYTES),
        .PTR_W(PTR_W)
    ) u_long_win (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .load(load),
        .frame(frame),
        .start(long_start),
        .window(long_custom_window)
    );

    akfe_window #(
        .FRAME_BYTES(FRAME_BYTES),
        .OUT_BYTES(akfe_pkg::SHORT_CUSTOM_BYTES),
        .PTR_W(PTR_W)
    ) u_short_win (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .load(load),
        .frame(frame),
        .start(short_start),
        .window(short_custom_window)
    );

    // ==========================================================
    // Transport flags.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tcp_seq_zero_flag <= 1'b0;
            tcp_finish_bit <= 1'b0;
            tcp_synchronize_bit <= 1'b0;
            tcp_reset_bit <= 1'b0;
            tcp_push_bit <= 1'b0;
            tcp_acknowledge_bit <= 1'b0;
            tcp_urgent_bit <= 1'b0;
            tcp_or_udp_flag <= 1'b0;
        end else if (clk_en && load) begin
            tcp_seq_zero_flag <= (tcp_sequence == akfe_pkg::SEQ_ZERO);
            tcp_finish_bit <= tcp_flags[akfe_pkg::FLAG_FIN];
            tcp_synchronize_bit <= tcp_flags[akfe_pkg::FLAG_SYN];
            tcp_reset_bit <= tcp_flags[akfe_pkg::FLAG_RST];
            tcp_push_bit <= tcp_flags[akfe_pkg::FLAG_PSH];
            tcp_acknowledge_bit <= tcp_flags[akfe_pkg::FLAG_ACK];
            tcp_urgent_bit <= tcp_flags[akfe_pkg::FLAG_URG];
            tcp_or_udp_flag <= next_tcp_or_udp;
        end
    end

    // ==========================================================
    // OAM flags.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loss_counters_zero_flag <= 1'b0;
            oam_ethertype_flag <= 1'b0;
            ethertype_key_field <= 16'h0000;
        end else if (clk_en && load) begin
            loss_counters_zero_flag <= is_ccm &&
                ((tx_fcf | rx_fcb | tx_fcb) == 32'h00000000);
            oam_ethertype_flag <= (ethertype == akfe_pkg::ETHERTYPE_KEY_FIELD_OAM);
            ethertype_key_field <= (ethertype == akfe_pkg::ETHERTYPE_KEY_FIELD_OAM) ?
                oam_level_flags : ethertype;
        end
    end

    // ==========================================================
    // Key valid and action word.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            key_valid <= 1'b0;
        end else if (clk_en) begin
            key_valid <= load;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            action_out_valid <= 1'b0;
            action_word <= '0;
        end else if (clk_en) begin
            action_out_valid <= action_valid;
            if (action_valid) begin
                // One format for all key types; inner flag at bit 0.
                action_word <= {action_rest, inner_switch_point};
            end
        end
    end
endmodule : akfe_key_extract

/* File: dv/akfe_frame_src.sv */
// Frame source standing in for the parser: byte n of the frame is n xor a salt.
module akfe_frame_src (
    input wire logic [7:0] salt,
    output logic [1023:0] frame
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        for (int n = 0; n < 128; n++) begin
            frame[8*n+:8] = 8'(n) ^ salt;
        end
    end
endmodule : akfe_frame_src

/* File: dv/akfe_chk.sv */
// Port assertions for the key extractor.
module akfe_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic frame_valid,
    input wire akfe_pkg::akfe_frame_t frame_type,
    input wire logic [7:0] ip_protocol,
    input wire logic [31:0] tcp_sequence,
    input wire logic [15:0] ethertype,
    input wire logic [15:0] oam_level_flags,
    input wire logic action_valid,
    input wire logic inner_switch_point,
    input wire logic [akfe_pkg::ACTION_WIDTH-2:0] action_rest,
    input wire logic key_valid,
    input wire logic tcp_seq_zero_flag,
    input wire logic tcp_or_udp_flag,
    input wire logic oam_ethertype_flag,
    input wire logic [15:0] ethertype_key_field,
    input wire logic action_out_valid,
    input wire logic [akfe_pkg::ACTION_WIDTH-1:0] action_word
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic tk = clk_en && frame_valid;
    wire logic ta = clk_en && action_valid;
    wire logic ip = frame_type != akfe_pkg::AKFE_FT_ETH;
    wire logic oam = ethertype == 16'h8902;
    a_seq_zero: assert property (tk |=> tcp_seq_zero_flag == ($past(tcp_sequence) == 32'h0))
        else $error("seq flag wrong");
    a_tcp_or_udp_flag: assert property (tk |=> tcp_or_udp_flag ==
        ($past(ip) && ($past(ip_protocol) == 8'h06 || $past(ip_protocol) == 8'h11)))
        else $error("tcp_or_udp_flag flag wrong");
    a_oam_flag: assert property (tk |=> oam_ethertype_flag == $past(oam))
        else $error("oam flag wrong");
    a_ethertype_key_field_sub: assert property (tk |=> ethertype_key_field ==
        ($past(oam) ? $past(oam_level_flags) : $past(ethertype))) else $error("ethertype_key_field wrong");
    a_action_pack: assert property (ta |=> action_out_valid &&
        action_word == {$past(action_rest), $past(inner_switch_point)}) else $error("action bad");
    a_action_idle: assert property (clk_en && !action_valid |=> !action_out_valid)
        else $error("action valid stray");
    a_key_take: assert property (tk |=> key_valid ##1
        (key_valid == ($past(tk) || (!$past(clk_en) && $past(key_valid)))))
        else $error("key valid wrong");
    a_flag_hold: assert property (!tk |=> $stable(tcp_seq_zero_flag) &&
        $stable(tcp_or_udp_flag) && ($past(clk_en) ? !key_valid : $stable(key_valid)))
        else $error("flags moved");
    c_oam: cover property (tk && oam);
    c_eth: cover property (tk && !ip);
    c_act: cover property (ta ##1 ta);
endmodule : akfe_chk
bind akfe_key_extract akfe_chk u_chk (.clock, .rst_n, .clk_en, .frame_valid, .frame_type,
    .ip_protocol, .tcp_sequence, .ethertype, .oam_level_flags, .action_valid,
    .inner_switch_point, .action_rest, .key_valid, .tcp_seq_zero_flag, .tcp_or_udp_flag,
    .oam_ethertype_flag, .ethertype_key_field, .action_out_valid, .action_word);

/* File: dv/akfe_key_extract_tb.sv */
// Self-checking bench for the key extractor.
module akfe_key_extract_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic frame_valid = 1'b0;
    logic clk_en = 1'b1;
    logic is_ccm = 1'b0;
    logic seven_tuple_key = 1'b0;
    logic action_valid = 1'b0;
    logic inner_switch_point = 1'b0;
    logic [7:0] salt = 8'h5a;
    logic [7:0] ip_protocol = 8'h06;
    logic [7:0] tcp_flags = 8'h2a;
    logic [31:0] tcp_sequence = 32'h0;
    logic [31:0] tx_fcf = 32'h0;
    logic [31:0] rx_fcb = 32'h0;
    logic [31:0] tx_fcb = 32'h0;
    logic [15:0] ethertype = 16'h0800;
    logic [15:0] oam_level_flags = 16'h00a5;
    logic [1:0] vlan_tag_count = 2'h0;
    logic [6:0] ip_header_start = 7'h0e;
    logic [6:0] ip_header_len = 7'h18;
    logic [6:0] transport_payload_start = 7'h4a;
    logic [6:0] frame_pointer = 7'h64;
    logic [6:0] short_custom_start = 7'h7c;
    logic [194:0] action_rest = 195'h5;
    akfe_pkg::akfe_frame_t frame_type = akfe_pkg::AKFE_FT_IPV4;
    logic [1023:0] frame;
    logic key_valid, tcp_seq_zero_flag, tcp_finish_bit, tcp_synchronize_bit, tcp_reset_bit;
    logic tcp_push_bit, tcp_acknowledge_bit, tcp_urgent_bit, tcp_or_udp_flag;
    logic loss_counters_zero_flag, oam_ethertype_flag, action_out_valid;
    logic [95:0] ip_payload_window;
    logic [63:0] transport_payload_window;
    logic [15:0] ethertype_key_field;
    logic [455:0] long_custom_window;
    logic [191:0] short_custom_window;
    logic [195:0] action_word;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    akfe_frame_src src (.salt, .frame);
    akfe_key_extract #(.FRAME_BYTES(128), .PTR_W(7)) dut (.clock, .rst_n, .clk_en,
        .frame_valid, .frame, .frame_type, .ip_header_start, .ip_header_len,
        .transport_payload_start, .ip_protocol, .tcp_sequence, .tcp_flags, .ethertype,
        .oam_level_flags, .is_ccm, .tx_fcf, .rx_fcb, .tx_fcb, .seven_tuple_key,
        .vlan_tag_count, .frame_pointer, .short_custom_start, .action_valid,
        .inner_switch_point, .action_rest, .key_valid, .tcp_seq_zero_flag, .tcp_finish_bit,
        .tcp_synchronize_bit, .tcp_reset_bit, .tcp_push_bit, .tcp_acknowledge_bit,
        .tcp_urgent_bit, .tcp_or_udp_flag, .ip_payload_window, .transport_payload_window,
        .loss_counters_zero_flag, .oam_ethertype_flag, .ethertype_key_field,
        .long_custom_window, .short_custom_window, .action_out_valid, .action_word);
    always #20 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end
    // Expected window: n bytes from frame byte s on, zero past the frame end.
    function automatic logic [455:0] win(input int s, input int n);
        logic [455:0] w;
        w = 456'h0;
        for (int i = 0; i < n; i++) begin
            if (s + i < 128) begin
                w[8*i+:8] = frame[8*(s+i)+:8];
            end
        end
        return w;
    endfunction : win
    task automatic chk(input string n, input logic [455:0] e, input logic [455:0] g);
        checks_done++;
        if (e !== g) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic take();
        @(posedge clock);
        #1;
        frame_valid = 1'b1;
        @(posedge clock);
        #1;
        frame_valid = 1'b0;
        chk("key_valid", 456'h1, 456'(key_valid));
    endtask : take
    task automatic t_ipv4();
        take();
        chk("ip", win(34, 12), 456'(ip_payload_window));
        chk("l4", win(74, 8), 456'(transport_payload_window));
        chk("long", win(100, 57), long_custom_window);
        chk("short", win(124, 24), 456'(short_custom_window));
        chk("flags", 456'h2a, 456'({tcp_urgent_bit, tcp_acknowledge_bit, tcp_push_bit,
            tcp_reset_bit, tcp_synchronize_bit, tcp_finish_bit}));
        chk("seq", 456'h1, 456'(tcp_seq_zero_flag));
        chk("oam4", 456'h0, 456'(oam_ethertype_flag));
        chk("etype4", 456'h0800, 456'(ethertype_key_field));
    endtask : t_ipv4
    task automatic t_ipv6();
        frame_type = akfe_pkg::AKFE_FT_IPV6;
        ip_header_len = 7'h28;
        ip_protocol = 8'h11;
        tcp_sequence = 32'h1;
        seven_tuple_key = 1'b1;
        transport_payload_start = 7'h3e;
        take();
        chk("ip6", win(54, 12), 456'(ip_payload_window));
        chk("l4_6", win(62, 8), 456'(transport_payload_window));
        chk("tcpudp", 456'h1, 456'(tcp_or_udp_flag));
    endtask : t_ipv6
    task automatic t_seven();
        frame_type = akfe_pkg::AKFE_FT_IPV4;
        ip_protocol = 8'h01;
        salt = 8'hc3;
        take();
        chk("l4_7", win(34, 8), 456'(transport_payload_window));
        chk("tcpudp", 456'h0, 456'(tcp_or_udp_flag));
    endtask : t_seven
    task automatic t_eth();
        frame_type = akfe_pkg::AKFE_FT_ETH;
        ip_protocol = 8'h06;
        ethertype = 16'h8902;
        is_ccm = 1'b1;
        for (int v = 0; v < 4; v++) begin
            vlan_tag_count = 2'(v);
            tx_fcb = 32'(v == 2);
            take();
            chk("long", win(14 + 4 * v, 57), long_custom_window);
            chk("short", win(14 + 4 * v, 24), 456'(short_custom_window));
            chk("loss", 456'(v != 2), 456'(loss_counters_zero_flag));
        end
        chk("ethertype_key_field", 456'h00a5, 456'(ethertype_key_field));
        chk("oam", 456'h1, 456'(oam_ethertype_flag));
        chk("tcpudp", 456'h0, 456'(tcp_or_udp_flag));
    endtask : t_eth
    // A take while the clock enable is low must leave every output frozen.
    task automatic t_freeze();
        @(posedge clock);
        #1;
        clk_en = 1'b0;
        frame_valid = 1'b1;
        tcp_sequence = 32'h0;
        ethertype = 16'h0800;
        @(posedge clock);
        #1;
        chk("kv_frz", 456'h0, 456'(key_valid));
        chk("oam_frz", 456'h1, 456'(oam_ethertype_flag));
        chk("seq_frz", 456'h0, 456'(tcp_seq_zero_flag));
        frame_valid = 1'b0;
        clk_en = 1'b1;
        take();
        chk("oam_run", 456'h0, 456'(oam_ethertype_flag));
        chk("ethertype_key_field_run", 456'h0800, 456'(ethertype_key_field));
        chk("seq_run", 456'h1, 456'(tcp_seq_zero_flag));
    endtask : t_freeze
    task automatic t_action();
        action_valid = 1'b1;
        inner_switch_point = 1'b1;
        @(posedge clock);
        #1;
        action_rest = {1'b1, 194'h3};
        inner_switch_point = 1'b0;
        chk("act", 456'({1'b1, 195'h5, 1'b1}), 456'({action_out_valid, action_word}));
        @(posedge clock);
        #1;
        action_valid = 1'b0;
        chk("act2", 456'({2'h3, 194'h3, 1'b0}), 456'({action_out_valid, action_word}));
    endtask : t_action
    task automatic final_report();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge clock);
        #1;
        rst_n = 1'b1;
        t_ipv4();
        t_ipv6();
        t_seven();
        t_eth();
        t_action();
        t_freeze();
        final_report();
    end
endmodule : akfe_key_extract_tb
